//--- verilog/inv_timer.sv
// three-phase inverter pwm timer: carrier, compares, buffers, outputs.
// assumes a cpu register port on sys_clk_i and an async output-off pin.
`include "inv_timer_cfg.svh"
`default_nettype none

module inv_timer (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // register port
   input wire inv_timer_pkg::reg_req_t reg_req_i,
   output logic [15:0] reg_rdata_o,
   // stop sources
   input wire logic output_off_input_i,
   input wire logic watchdog_irq_i,
   // gate pins, three-state as value plus enable
   output logic [5:0] gate_output_o,
   output logic [5:0] gate_oe_o,
   // interrupt pulses
   output logic gated_underflow_irq_o,
   output logic trigger_a_match_irq_o,
   output logic trigger_b_match_irq_o
);

   logic [7:0] ctrl;
   logic [7:0] mode;
   logic output_enabled_flag;
   logic [7:0] dead_time_reload;
   logic [9:0] cmp [0:5];
   logic [9:0] buffer [0:5];
   logic [9:0] carrier_updown_counter;
   logic [9:0] next_cnt;
   inv_timer_pkg::cnt_dir_t dir;
   inv_timer_pkg::cnt_dir_t next_dir;
   logic [4:0] prescale;
   logic [4:0] tick_mask;
   logic tick;
   logic underflow;
   logic [2:0] underflow_divider;
   logic [2:0] div_inc;
   logic [2:0] phase_ff;
   logic [2:0] phase_match;
   inv_timer_pkg::phase_act_t act [0:2];
   logic off_sync1;
   logic off_sync2;
   logic off_prev;
   logic off_edge;
   logic stop_evt;
   logic ctrl_wr;
   logic ce;
   logic ce_rise;
   logic ce_fall;
   logic drive;
   logic [15:0] next_rdata;

   // merge a word or byte write into a 10-bit register
   function automatic logic [9:0] merge10(input logic [9:0] cur,
                                          input logic [15:0] wd,
                                          input logic bsel,
                                          input logic hi);
      logic [9:0] res;
      res = cur;
      if (hi) begin
         res[9:8] = wd[1:0];
      end else if (bsel) begin
         res[7:0] = wd[7:0];
      end else begin
         res = wd[9:0];
      end
      return res;
   endfunction

   assign ce = ctrl[`CE_BIT];
   assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == `CTRL_ADDR;
   assign ce_rise = ctrl_wr && reg_req_i.wdata[`CE_BIT] && !ce;
   assign ce_fall = ctrl_wr && !reg_req_i.wdata[`CE_BIT] && ce;

   // control register, software owned; write mask keeps bit 6 at zero
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ctrl <= `CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl <= reg_req_i.wdata[7:0] & `CTRL_WMASK;
      end
   end

   // mode register; the status bit lives apart and is read-only
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         mode <= `MODE_RST;
      end else if (reg_req_i.wr && reg_req_i.addr == `MODE_ADDR) begin
         mode <= reg_req_i.wdata[7:0] & `MODE_WMASK;
      end
   end

   // dead-time reload only changes while the carrier is stopped
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         dead_time_reload <= `DTIME_RST;
      end else if (reg_req_i.wr && reg_req_i.addr == `DTIME_ADDR
                   && !ce) begin
         dead_time_reload <= reg_req_i.wdata[7:0];
      end
   end

   // count clock prescaler; prohibited codes fall back to /32
   always_comb begin
      case (ctrl[`TCL_MSB:`TCL_LSB])
         3'h0: tick_mask = 5'h00;
         3'h1: tick_mask = 5'h01;
         3'h2: tick_mask = 5'h03;
         3'h3: tick_mask = 5'h07;
         3'h4: tick_mask = 5'h0F;
         default: tick_mask = 5'h1F;
      endcase
   end
   assign tick = ce && ((prescale & tick_mask) == tick_mask);

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !ce) begin
         prescale <= 5'h00;
      end else begin
         prescale <= prescale + 5'h01;
      end
   end

   // next carrier value; turn at period or zero on the next count
   always_comb begin
      next_cnt = carrier_updown_counter;
      next_dir = dir;
      case (dir)
         inv_timer_pkg::CNT_UP: begin
            if (carrier_updown_counter == cmp[`PERIOD_IDX]) begin
               next_cnt = carrier_updown_counter - 10'h001;
               next_dir = inv_timer_pkg::CNT_DOWN;
            end else begin
               next_cnt = carrier_updown_counter + 10'h001;
            end
         end
         default: begin
            if (carrier_updown_counter == 10'h000) begin
               next_cnt = 10'h001;
               next_dir = inv_timer_pkg::CNT_UP;
            end else begin
               next_cnt = carrier_updown_counter - 10'h001;
            end
         end
      endcase
   end
   // underflow: reaching zero while counting down
   assign underflow = tick && dir == inv_timer_pkg::CNT_DOWN
                      && next_cnt == 10'h000;

   // carrier counter, cleared and held while disabled
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !ce) begin
         carrier_updown_counter <= 10'h000;
         dir <= inv_timer_pkg::CNT_UP;
      end else if (tick) begin
         carrier_updown_counter <= next_cnt;
         dir <= next_dir;
      end
   end

   // underflow divider; the irq flop doubles as the transfer strobe
   assign div_inc = underflow_divider + 3'h1;
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !ce) begin
         underflow_divider <= `DIV_RST;
         gated_underflow_irq_o <= 1'b0;
      end else if (underflow
                   && div_inc == ctrl[`IDEV_MSB:`IDEV_LSB]) begin
         underflow_divider <= `DIV_RST;
         gated_underflow_irq_o <= 1'b1;
      end else begin
         gated_underflow_irq_o <= 1'b0;
         if (underflow) begin
            underflow_divider <= div_inc;
         end
      end
   end

   // buffers and compares, one slice per index
   for (genvar i = 0; i < 6; i++) begin : g_cmp
      localparam logic [15:0] BUF_ADDR = `BUF_BASE + 16'(2 * i);
      localparam logic [15:0] CMP_ADDR = `CMP_BASE + 16'(2 * i);
      localparam logic [9:0] RST_VAL =
         (i == `PERIOD_IDX) ? `PERIOD_RST : `CMP_RST;
      logic buf_lo;
      logic buf_hi;
      logic cmp_lo;
      logic cmp_hi;
      assign buf_lo = reg_req_i.wr && reg_req_i.addr == BUF_ADDR;
      assign buf_hi = reg_req_i.wr && reg_req_i.byte_sel
                      && reg_req_i.addr == BUF_ADDR + 16'h0001;
      assign cmp_lo = reg_req_i.wr && reg_req_i.addr == CMP_ADDR;
      assign cmp_hi = reg_req_i.wr && reg_req_i.byte_sel
                      && reg_req_i.addr == CMP_ADDR + 16'h0001;

      // buffer writable whether or not the carrier runs
      always_ff @(posedge sys_clk_i) begin
         if (!rstn_i) begin
            buffer[i] <= RST_VAL;
         end else if (buf_lo || buf_hi) begin
            buffer[i] <= merge10(buffer[i], reg_req_i.wdata,
                                 reg_req_i.byte_sel, buf_hi);
         end
      end

      // compare: cleared on stop except the period, loaded at transfer, written stopped
      always_ff @(posedge sys_clk_i) begin
         if (!rstn_i) begin
            cmp[i] <= RST_VAL;
         end else if (ce_fall && i != `PERIOD_IDX) begin
            cmp[i] <= `CMP_RST;
         end else if (gated_underflow_irq_o) begin
            cmp[i] <= buffer[i];
         end else if (!ce && (cmp_lo || cmp_hi)) begin
            cmp[i] <= merge10(cmp[i], reg_req_i.wdata,
                              reg_req_i.byte_sel, cmp_hi);
         end
      end
   end

   // phase flip-flops toggle when the carrier steps onto a compare
   for (genvar c = 0; c < 3; c++) begin : g_phase
      assign phase_match[c] = tick && next_cnt == cmp[c];
      always_ff @(posedge sys_clk_i) begin
         if (!rstn_i || !ce) begin
            phase_ff[c] <= 1'b0;
         end else if (phase_match[c]) begin
            phase_ff[c] <= ~phase_ff[c];
         end
      end

      dead_time_channel u_dead_time (
         .sys_clk_i(sys_clk_i),
         .rstn_i(rstn_i),
         .ce_i(ce),
         .match_i(phase_match[c]),
         .phase_i(phase_ff[c]),
         .reload_i(dead_time_reload),
         .act_o(act[c])
      );

      // registered pins: enable, then level per chosen polarity
      always_ff @(posedge sys_clk_i) begin
         if (!rstn_i) begin
            gate_output_o[2 * c] <= 1'b0;
            gate_output_o[2 * c + 1] <= 1'b0;
            gate_oe_o[2 * c] <= 1'b0;
            gate_oe_o[2 * c + 1] <= 1'b0;
         end else begin
            gate_oe_o[2 * c] <= drive;
            gate_oe_o[2 * c + 1] <= drive;
            gate_output_o[2 * c] <= drive
               && (mode[`ALV_BIT] ? act[c].pos : ~act[c].pos);
            gate_output_o[2 * c + 1] <= drive
               && (mode[`ALV_BIT] ? act[c].neg : ~act[c].neg);
         end
      end
   end

   // trigger compare interrupts, one-cycle pulses
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         trigger_a_match_irq_o <= 1'b0;
         trigger_b_match_irq_o <= 1'b0;
      end else begin
         trigger_a_match_irq_o <= tick && next_cnt == cmp[4];
         trigger_b_match_irq_o <= tick && next_cnt == cmp[5];
      end
   end

   // off pin: two-stage synchroniser, then an edge detector after it
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         off_sync1 <= 1'b0;
         off_sync2 <= 1'b0;
         off_prev <= 1'b0;
      end else begin
         off_sync1 <= output_off_input_i;
         off_sync2 <= off_sync1;
         off_prev <= off_sync2;
      end
   end
   assign off_edge = mode[`EDGE_BIT] ? (off_sync2 && !off_prev)
                                     : (!off_sync2 && off_prev);
   assign stop_evt = ce && ((mode[`STOP_BIT] && off_edge)
                            || watchdog_irq_i);

   // status flag: the start write sets it while ce is still low;
   // a start never meets a stop, since every stop needs ce high
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         output_enabled_flag <= 1'b0;
      end else if (ce_rise) begin
         output_enabled_flag <= 1'b1;
      end else if (!ce || ce_fall || stop_evt) begin
         output_enabled_flag <= 1'b0;
      end
   end
   // the start cycle itself also sets the flag next edge
   always_comb begin
      drive = ce && output_enabled_flag;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (reg_req_i.addr == `CTRL_ADDR) begin
         next_rdata = {8'h00, ctrl};
      end else if (reg_req_i.addr == `MODE_ADDR) begin
         next_rdata = {8'h00, mode | ({7'h00, output_enabled_flag}
                                      << `FLAG_BIT)};
      end else if (reg_req_i.addr == `DTIME_ADDR) begin
         next_rdata = {8'h00, dead_time_reload};
      end
      for (int k = 0; k < 6; k++) begin
         if (reg_req_i.addr == `BUF_BASE + 16'(2 * k)) begin
            next_rdata = {6'h00, buffer[k]};
         end else if (reg_req_i.addr == `BUF_BASE + 16'(2 * k + 1)) begin
            next_rdata = {14'h0000, buffer[k][9:8]};
         end else if (reg_req_i.addr == `CMP_BASE + 16'(2 * k)) begin
            next_rdata = {6'h00, cmp[k]};
         end
      end
   end

   // read data registered, valid one cycle after the address
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

endmodule

`default_nettype wire

//--- verilog/inv_timer_cfg.svh
// constants of the three-phase dead-time pwm timer: addresses, fields,
// reset values. assumes inclusion by every file that uses its macros; the package does not include it.
`ifndef INV_TIMER_CFG_SVH
`define INV_TIMER_CFG_SVH

// register addresses
`define CTRL_ADDR 16'hFF88
`define MODE_ADDR 16'hFF89
`define DTIME_ADDR 16'hFF8A
`define BUF_BASE 16'hFF90
`define CMP_BASE 16'hFFA0

// control register fields
`define CE_BIT 7
`define TCL_MSB 5
`define TCL_LSB 3
`define IDEV_MSB 2
`define IDEV_LSB 0
`define CTRL_WMASK 8'hBF

// mode register fields
`define FLAG_BIT 4
`define ALV_BIT 3
`define EDGE_BIT 2
`define STOP_BIT 1
`define MODE_WMASK 8'h0E

// reset values, plus the index of the period compare
`define CTRL_RST 8'h00
`define MODE_RST 8'h00
`define PERIOD_RST 10'h0FF
`define CMP_RST 10'h000
`define DTIME_RST 8'hFF
`define DIV_RST 3'h7
`define DT_IDLE 8'hFF
`define PERIOD_IDX 3

`endif

//--- verilog/inv_timer_pkg.sv
// types shared by the pwm timer and its dead-time channels.
// assumes nothing beyond a systemverilog compiler.
`default_nettype none

package inv_timer_pkg;

   // one register access from the cpu side
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic byte_sel;
   } reg_req_t;

   // carrier counting direction, one-hot
   typedef enum logic [1:0] {
      CNT_UP = 2'b01,
      CNT_DOWN = 2'b10
   } cnt_dir_t;

   // active state of one complementary phase pair
   typedef struct packed {
      logic pos;
      logic neg;
   } phase_act_t;

endpackage

`default_nettype wire

//--- verilog/dead_time_channel.sv
// one 8-bit dead-time down counter and its complementary pair.
// assumes match pulses and phase level come from the same clock.
`include "inv_timer_cfg.svh"
`default_nettype none

module dead_time_channel (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // control from the carrier side
   input wire logic ce_i,
   input wire logic match_i,
   input wire logic phase_i,
   input wire logic [7:0] reload_i,
   // pair activity
   output inv_timer_pkg::phase_act_t act_o
);

   logic [7:0] dt_cnt;
   logic running;

   // reload on match, count down, wrap 00 to FF and halt there
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i || !ce_i) begin
         dt_cnt <= `DT_IDLE;
         running <= 1'b0;
      end else if (match_i) begin
         dt_cnt <= reload_i;
         running <= 1'b1;
      end else if (running) begin
         dt_cnt <= dt_cnt - 8'h01;
         // underflow ends the gap; reload N gives N+1 cycles
         if (dt_cnt == 8'h00) begin
            running <= 1'b0;
         end
      end
   end

   // both sides stay inactive while the gap runs, 00 still gives one
   assign act_o.pos = phase_i & ~running;
   assign act_o.neg = ~phase_i & ~running;

endmodule

`default_nettype wire

//--- verification/inv_timer_asserts.sv
// port checker for the pwm timer: enables, pulses, leg overlap.
// assumes it is bound to inv_timer and sees only its ports.
`include "inv_timer_cfg.svh"
`default_nettype none

module inv_timer_asserts (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // timer inputs
   input wire inv_timer_pkg::reg_req_t reg_req_i,
   input wire logic output_off_input_i,
   input wire logic watchdog_irq_i,
   // timer outputs
   input wire logic [15:0] reg_rdata_o,
   input wire logic [5:0] gate_output_o,
   input wire logic [5:0] gate_oe_o,
   input wire logic gated_underflow_irq_o,
   input wire logic trigger_a_match_irq_o,
   input wire logic trigger_b_match_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   logic ce;
   logic alv;
   logic ctrl_wr;
   logic [2:0] both_on;

   // shadows from port writes; level follows every mode write, running or stopped
   assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == `CTRL_ADDR;
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) ce <= 1'b0;
      else if (ctrl_wr) ce <= reg_req_i.wdata[`CE_BIT];
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) alv <= 1'b0;
      else if (reg_req_i.wr && reg_req_i.addr == `MODE_ADDR)
         alv <= reg_req_i.wdata[`ALV_BIT];
   end

   // both switches of a leg active would short the supply
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         both_on[c] = gate_output_o[2*c] == alv;
         both_on[c] = both_on[c] && gate_output_o[2*c+1] == alv;
      end
   end

   a_reset_quiet: assert property (
      $rose(rstn_i) |-> gate_oe_o == 6'h00 && gate_output_o == 6'h00)
      else $error("outputs live after reset");
   a_oe_all_six: assert property (
      gate_oe_o == 6'h00 || gate_oe_o == 6'h3F)
      else $error("gate enables split");
   a_idle_pins_low: assert property (
      gate_oe_o == 6'h00 |-> gate_output_o == 6'h00)
      else $error("released pins not low");
   a_stop_write_off: assert property (
      ctrl_wr && !reg_req_i.wdata[7] |-> ##[1:3] gate_oe_o == 6'h00)
      else $error("enables kept after stop");
   a_start_write_on: assert property (
      ctrl_wr && reg_req_i.wdata[7] && !ce && !watchdog_irq_i
      |-> ##[1:3] gate_oe_o == 6'h3F)
      else $error("enables missing after start");
   a_watchdog_off: assert property (
      ce && watchdog_irq_i |-> ##[1:3] gate_oe_o == 6'h00)
      else $error("enables kept after watchdog");
   a_irq_one_cycle: assert property (
      gated_underflow_irq_o |=> !gated_underflow_irq_o)
      else $error("underflow pulse too long");
   a_trig_one_cycle: assert property (
      trigger_a_match_irq_o |=> !trigger_a_match_irq_o)
      else $error("trigger pulse too long");
   a_stopped_silent: assert property (
      !ce [*3] |-> !gated_underflow_irq_o && !trigger_a_match_irq_o)
      else $error("pulse while stopped");
   a_no_overlap: assert property (
      gate_oe_o == 6'h3F |-> both_on == 3'h0)
      else $error("leg overlap");

   c_irq: cover property (gated_underflow_irq_o);
   c_trig: cover property (trigger_a_match_irq_o);
   c_trip: cover property (gate_oe_o == 6'h3F ##1 gate_oe_o == 6'h00);
endmodule

bind inv_timer inv_timer_asserts checker_i (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i),
   .output_off_input_i(output_off_input_i),
   .watchdog_irq_i(watchdog_irq_i), .reg_rdata_o(reg_rdata_o),
   .gate_output_o(gate_output_o), .gate_oe_o(gate_oe_o),
   .gated_underflow_irq_o(gated_underflow_irq_o),
   .trigger_a_match_irq_o(trigger_a_match_irq_o),
   .trigger_b_match_irq_o(trigger_b_match_irq_o)
);

`default_nettype wire

//--- verification/gate_stage_model.sv
// power stage model: resolves gate pins, drives the output-off line.
// assumes the bench sets the fault level it wants on the line.
`default_nettype none

module gate_stage_model (
   // clock
   input wire logic sys_clk_i,
   // from the timer and the bench
   input wire logic [5:0] gate_i,
   input wire logic [5:0] oe_i,
   input wire logic fault_i,
   // to the bench and the timer
   output logic [5:0] pin_o,
   output logic off_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] last = 6'h00;

   // no pull on the pins: a released pin shows its last level inverted
   always @(posedge sys_clk_i) last <= (gate_i & oe_i) | (last & ~oe_i);
   assign pin_o = (gate_i & oe_i) | (~last & ~oe_i);

   // fault comparator answers off the clock grid
   initial off_o = 1'b1;
   always @(fault_i) off_o <= #7 fault_i;
endmodule

`default_nettype wire

//--- verification/inv_timer_tb.sv
// self-checking bench for the three-phase pwm timer.
// assumes the gate stage model and the bound port checker.
`include "inv_timer_cfg.svh"
`default_nettype none

module inv_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   inv_timer_pkg::reg_req_t req = '0;
   logic wdg = 1'b0;
   logic fault = 1'b1;
   logic [15:0] rdata;
   logic [5:0] gate, oe, pin;
   logic off, uirq, tirq_a, tirq_b;
   logic [9:0] per, cv;
   logic [7:0] dt;
   int n_fail = 0;
   int samples_checked = 0;

   // 20 MHz system clock
   always #25 sys_clk_i = ~sys_clk_i;

   inv_timer dut (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .output_off_input_i(off),
      .watchdog_irq_i(wdg), .gate_output_o(gate), .gate_oe_o(oe),
      .gated_underflow_irq_o(uirq), .trigger_a_match_irq_o(tirq_a),
      .trigger_b_match_irq_o(tirq_b)
   );
   gate_stage_model stage (
      .sys_clk_i(sys_clk_i), .gate_i(gate), .oe_i(oe),
      .fault_i(fault), .pin_o(pin), .off_o(off)
   );

   // clocks between gated pulses: up and down pass, divided, gated
   function automatic int irq_gap(int p, int t, int d);
      return 2 * p * (1 << t) * (d + 1);
   endfunction

   task automatic chk(input logic [15:0] e, input logic [15:0] g,
                      input string n);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask

   // one write, strobe high for a single edge
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic b = 1'b0);
      @(posedge sys_clk_i);
      req <= '{a, d, 1'b1, b};
      @(posedge sys_clk_i);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      req.addr <= a;
      @(posedge sys_clk_i);
      #1 chk(e, rdata, $sformatf("reg %h", a));
   endtask

   // bounded wait for the next gated pulse, counting trigger pulses
   task automatic wait_irq(output int n, output int nt);
      n = 0;
      nt = 0;
      do begin
         @(posedge sys_clk_i);
         #1 n++;
         if (tirq_a === 1'b1) nt++;
         if (tirq_b === 1'b1) nt++;
      end while (uirq !== 1'b1 && n < 9000);
      if (n >= 9000) begin
         $display("ERROR irq wait expected pulse seen none");
         n_fail++;
         report_and_stop();
      end
   endtask

   task automatic rst_chk();
      @(posedge sys_clk_i);
      rstn_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      rd(`CTRL_ADDR, 16'h0000);
      rd(`MODE_ADDR, 16'h0000);
      rd(`DTIME_ADDR, 16'h00FF);
      for (int k = 0; k < 6; k++) begin
         rd(`BUF_BASE + 16'(2 * k), k == 3 ? 16'h00FF : 16'h0000);
         rd(`CMP_BASE + 16'(2 * k), k == 3 ? 16'h00FF : 16'h0000);
      end
      rd(16'hFF80, 16'h0000);
   endtask

   task automatic run_cfg(input int i);
      int n, nt, g;
      logic [2:0] tcl, idv;
      logic alv;
      tcl = (i < 6) ? 3'(i) : 3'h5;
      idv = 3'(i);
      alv = i[0];
      per = 10'($urandom_range(6, 3));
      cv = 10'($urandom_range(per - 1, 1));
      dt = (i == 6) ? 8'h00 : 8'($urandom_range(20, 1));
      wr(`CTRL_ADDR, {10'h000, tcl, idv});
      wr(`MODE_ADDR, {12'h000, alv, 3'h0});
      wr(`DTIME_ADDR, {8'h00, dt});
      for (int k = 0; k < 6; k++) begin
         wr(`BUF_BASE + 16'(2 * k), 16'(k == 3 ? per : cv));
         wr(`CMP_BASE + 16'(2 * k), 16'(k == 3 ? per : cv));
      end
      wr(`CTRL_ADDR, {8'h00, 2'b10, tcl, idv});
      repeat (3) @(posedge sys_clk_i);
      #1 chk(16'h003F, {10'h000, oe}, "gate enables");
      rd(`MODE_ADDR, {11'h000, 1'b1, alv, 3'h0});
      wait_irq(n, nt);
      wait_irq(n, nt);
      chk(16'(irq_gap(per, tcl, idv)), 16'(n), "irq period");
      chk(16'(4 * idv + 4), 16'(nt), "trigger pulses");
      // slow carrier only, so one gap never runs into the next match
      if (tcl == 3'h5) begin
         g = 0;
         for (n = 0; n < 3000 && pin[1:0] !== {2{~alv}}; n++) begin
            @(posedge sys_clk_i);
            #1;
         end
         while (pin[1:0] === {2{~alv}} && g < 300) begin
            @(posedge sys_clk_i);
            #1 g++;
         end
         chk(16'(dt) + 16'h0001, 16'(g), "dead gap");
      end
      wr(`DTIME_ADDR, {8'h00, ~dt});
      rd(`DTIME_ADDR, {8'h00, dt});
      wr(`CMP_BASE + 16'h0008, 16'(per));
      rd(`CMP_BASE + 16'h0008, 16'(cv));
      wr(`BUF_BASE + 16'h0006, 16'(per + 1));
      wait_irq(n, nt);
      rd(`CMP_BASE + 16'h0006, 16'(per + 1));
      wr(`CTRL_ADDR, {10'h000, tcl, idv});
      rd(`CMP_BASE + 16'h0008, 16'h0000);
      rd(`CMP_BASE + 16'h0006, 16'(per + 1));
      rd(`MODE_ADDR, {12'h000, alv, 3'h0});
   endtask

   // trip on the chosen edge, then stop the timer and clear the mode register
   task automatic off_test(input logic e);
      int n, nt;
      fault <= ~e;
      wr(`MODE_ADDR, {12'h000, 1'b1, e, 2'b10});
      wr(`CTRL_ADDR, 16'h0080);
      wait_irq(n, nt);
      fault <= e;
      repeat (8) @(posedge sys_clk_i);
      #1 chk(16'h0000, {10'h000, oe}, "oe after trip");
      rd(`MODE_ADDR, {11'h000, 1'b0, 1'b1, e, 2'b10});
      wait_irq(n, nt);
      wr(`CTRL_ADDR, 16'h0000);
      wr(`MODE_ADDR, 16'h0000);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      void'($urandom(51078));
      rst_chk();
      per = 10'($urandom_range(1023, 0));
      wr(`BUF_BASE + 16'h0002, 16'(per));
      rd(`BUF_BASE + 16'h0002, 16'(per));
      wr(`BUF_BASE + 16'h0002, 16'h00A5, 1'b1);
      wr(`BUF_BASE + 16'h0003, 16'h0002, 1'b1);
      rd(`BUF_BASE + 16'h0002, 16'h02A5);
      for (int i = 0; i < 8; i++) run_cfg(i);
      off_test(1'b0);
      off_test(1'b1);
      wr(`CTRL_ADDR, 16'h0080);
      @(posedge sys_clk_i);
      wdg <= 1'b1;
      @(posedge sys_clk_i);
      wdg <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1 chk(16'h0000, {10'h000, oe}, "oe after watchdog");
      rd(`MODE_ADDR, 16'h0000);
      rst_chk();
      report_and_stop();
   end
endmodule

`default_nettype wire
